/* rtl/sleep2_iq_defs.vh */
// Register offsets, field positions, reset values and timing constants
// for the deep-sleep poll interval and image-quality gate block.
// Assumes inclusion by bare name from the design files.
`ifndef SLEEP2_IQ_DEFS_VH
`define SLEEP2_IQ_DEFS_VH

// Register indices (printed offsets); byte address is four times the index
`define IDX_POLL_INTERVAL 4'h0c
`define IDX_QUALITY_GATE 4'h0d
`define IDX_RECOGNITION 4'h0e
// Registers of our own: measured quality and last accepted displacement
`define IDX_QUALITY_MEAS 4'h0f
`define IDX_MOTION_COUNT 5'h10
`define ADDR_LSB 2

// Reset values
`define RST_POLL_INTERVAL 8'h92
`define RST_QUALITY_GATE 8'h0a
`define RST_RECOGNITION 8'he9
`define POLL_LOW_FIXED 4'h2

// Field positions
`define POLL_FIELD_HI 7
`define POLL_FIELD_LO 4
`define PEAK_WT_HI 7
`define PEAK_WT_LO 5
`define RECOG_ZERO_BIT 4
`define QDIFF_HI 3
`define QDIFF_LO 0

// Timing: poll step in ms, clock in kHz
`define POLL_STEP_MS 32
`define CLK_KHZ 100000

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* rtl/poll_timer.v */
// Deep-sleep poll timer: one-cycle pulse every (interval + 1) steps.
// Counts its own steps of STEP_CYCLES clocks; needs no step enable from the caller.
`timescale 1ns/100ps
module poll_timer #(
    parameter STEP_CYCLES = 3200000
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Control
    input wire run,
    input wire [3:0] interval,
    // Result
    output reg poll_pulse
);

reg [31:0] cyc_q;
reg [3:0] step_q;
wire step_end = (cyc_q == STEP_CYCLES - 1);

always @(posedge aclk) begin
    if (!aresetn || !run) begin
        cyc_q <= 32'h0000_0000;
        step_q <= 4'h0;
        poll_pulse <= 1'b0;
    end else begin
        poll_pulse <= 1'b0;
        if (step_end) begin
            cyc_q <= 32'h0000_0000;
            // Interval field n gives n+1 steps of 32 ms
            if (step_q >= interval) begin
                step_q <= 4'h0;
                poll_pulse <= 1'b1;
            end else begin
                step_q <= step_q + 4'h1;
            end
        end else begin
            cyc_q <= cyc_q + 32'h0000_0001;
        end
    end
end

endmodule

/* rtl/sleep2_iq_config.v */
// Deep-sleep poll interval and image-quality gate configuration block.
// Assumes an AXI4-Lite master, one clock at 100 MHz, and an imaging
// core that supplies quality metric and displacement per frame.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "sleep2_iq_defs.vh"
module sleep2_iq_config #(
    parameter STEP_CYCLES = `POLL_STEP_MS * `CLK_KHZ
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Imaging core
    input wire deep_sleep,
    input wire frame_valid,
    input wire [7:0] quality_metric,
    input wire [7:0] frame_dx,
    input wire [7:0] frame_dy,
    // Outputs to the core
    output wire poll_pulse,
    output reg [7:0] motion_x_q,
    output reg [7:0] motion_y_q,
    output reg motion_load_q,
    output wire [2:0] peak_weighting,
    output wire [3:0] quality_difference_level
);

// Configuration registers; the fixed bits are forced on every write
reg [7:0] poll_reg_q;
reg [7:0] gate_q;
reg [7:0] recog_q;
reg [7:0] quality_seen_q;
// Halves of a write taken ahead of their partner wait here
reg [7:0] awaddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg aw_held_q;
reg w_held_q;

////////////////////////////////////////////////////////////////////////
// Write path: address and data taken in either order, answered after both

assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
assign s_axi_wready = !w_held_q && !s_axi_bvalid;

wire aw_ok = aw_held_q || (s_axi_awvalid && s_axi_awready);
wire w_ok = w_held_q || (s_axi_wvalid && s_axi_wready);
wire [7:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
// Refused while a response waits, so one write at most is under way
wire do_write = aw_ok && w_ok && !s_axi_bvalid;
wire [5:0] wr_idx = wr_addr[7:`ADDR_LSB];
wire wr_lane0 = wr_strb[0];

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        awaddr_q <= 8'h00;
        wdata_q <= 32'h0000_0000;
        wstrb_q <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
        poll_reg_q <= `RST_POLL_INTERVAL;
        gate_q <= `RST_QUALITY_GATE;
        recog_q <= `RST_RECOGNITION;
    end else begin
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            // Byte lane 0 carries the 8-bit register; other lanes ignored
            if (wr_idx == {2'b00, `IDX_POLL_INTERVAL}) begin
                if (wr_lane0) begin
                    // Low nibble is held at its fixed pattern whatever is written
                    poll_reg_q <= {wr_data[`POLL_FIELD_HI:`POLL_FIELD_LO], `POLL_LOW_FIXED};
                end
            end else if (wr_idx == {2'b00, `IDX_QUALITY_GATE}) begin
                // Full 0..255 accepted; values below 10 are the host's fault
                if (wr_lane0) begin
                    gate_q <= wr_data[7:0];
                end
            end else if (wr_idx == {2'b00, `IDX_RECOGNITION}) begin
                if (wr_lane0) begin
                    recog_q <= {wr_data[`PEAK_WT_HI:`PEAK_WT_LO], 1'b0, wr_data[`QDIFF_HI:`QDIFF_LO]};
                end
            end else if (wr_idx == {2'b00, `IDX_QUALITY_MEAS} || wr_idx == {1'b0, `IDX_MOTION_COUNT}) begin
                // Own read-only registers: answered OKAY, the data dropped
                s_axi_bresp <= `RESP_OKAY;
            end else begin
                s_axi_bresp <= `RESP_SLVERR;
            end
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Read path: one cycle after the address is taken

// Only one read may wait for rready; a new address is refused till then
assign s_axi_arready = !s_axi_rvalid;
wire [5:0] rd_idx = s_axi_araddr[7:`ADDR_LSB];
// Data is registered, so it stands unchanged while rvalid waits

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        if (rd_idx == {2'b00, `IDX_POLL_INTERVAL}) begin
            s_axi_rdata <= {24'h00_0000, poll_reg_q};
        end else if (rd_idx == {2'b00, `IDX_QUALITY_GATE}) begin
            s_axi_rdata <= {24'h00_0000, gate_q};
        end else if (rd_idx == {2'b00, `IDX_RECOGNITION}) begin
            s_axi_rdata <= {24'h00_0000, recog_q};
        end else if (rd_idx == {2'b00, `IDX_QUALITY_MEAS}) begin
            s_axi_rdata <= {24'h00_0000, quality_seen_q};
        end else if (rd_idx == {1'b0, `IDX_MOTION_COUNT}) begin
            s_axi_rdata <= {16'h0000, motion_y_q, motion_x_q};
        end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
        end
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// Quality gate: strict greater-than, so a gate of 255 blocks all motion

// A frame that fails the gate leaves the motion registers as they were,
// so the core keeps the last good displacement rather than a noisy one
wire accept = frame_valid && (quality_metric > gate_q);

always @(posedge aclk) begin
    if (!aresetn) begin
        motion_x_q <= 8'h00;
        motion_y_q <= 8'h00;
        motion_load_q <= 1'b0;
        quality_seen_q <= 8'h00;
    end else begin
        motion_load_q <= accept;
        // Metric kept whether or not the frame passed, to help tune the gate
        if (frame_valid) begin
            quality_seen_q <= quality_metric;
        end
        if (accept) begin
            motion_x_q <= frame_dx;
            motion_y_q <= frame_dy;
        end
    end
end

// Recognition fields go straight to the core; no shadow copy is needed
assign peak_weighting = recog_q[`PEAK_WT_HI:`PEAK_WT_LO];
assign quality_difference_level = recog_q[`QDIFF_HI:`QDIFF_LO];

////////////////////////////////////////////////////////////////////////
// Deep-sleep poll timer
// Counter is held at zero while awake, so the first poll after entry
// comes one full interval later, never at once

poll_timer #(
    .STEP_CYCLES(STEP_CYCLES)
) u_poll (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(deep_sleep),
    .interval(poll_reg_q[`POLL_FIELD_HI:`POLL_FIELD_LO]),
    .poll_pulse(poll_pulse)
);

endmodule

/* test/sleep2_iq_monitor.sv */
// Port checker for the deep-sleep poll and quality gate block.
// Assumes a bind onto sleep2_iq_config with one clock.
`timescale 1ns/100ps
module sleep2_iq_monitor (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Core side
    input wire deep_sleep,
    input wire frame_valid,
    input wire [7:0] frame_dx,
    input wire poll_pulse,
    input wire [7:0] motion_x_q,
    input wire motion_load_q,
    input wire [2:0] peak_weighting,
    input wire [3:0] quality_difference_level
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
AST_LOAD_SRC: assert property (motion_load_q |-> $past(frame_valid) && motion_x_q == $past(frame_dx))
    else $error("load without frame");
AST_NO_LOAD: assert property (!frame_valid |=> !motion_load_q)
    else $error("load with no frame");
AST_HOLD: assert property (!motion_load_q |-> $stable(motion_x_q))
    else $error("motion moved without load");
AST_PK_RST: assert property ($rose(aresetn) |-> peak_weighting == 3'h7)
    else $error("peak weighting reset");
AST_QD_RST: assert property ($rose(aresetn) |-> quality_difference_level == 4'h9)
    else $error("difference level reset");
AST_POLL_GAP: assert property (poll_pulse |=> !poll_pulse [*3])
    else $error("poll pulses too close");
AST_POLL_IDLE: assert property (!deep_sleep && !$past(deep_sleep) |-> !poll_pulse)
    else $error("poll outside deep sleep");
AST_FIRST_POLL: assert property ($rose(deep_sleep) |-> !poll_pulse [*4])
    else $error("early first poll");
endmodule
bind sleep2_iq_config sleep2_iq_monitor mon_u (.aclk, .aresetn, .deep_sleep, .frame_valid, .frame_dx,
    .poll_pulse, .motion_x_q, .motion_load_q, .peak_weighting, .quality_difference_level);

/* test/core_model.sv */
// Imaging core stand-in: sleep level and one-cycle frames.
// Assumes the caller runs on aclk.
`timescale 1ns/100ps
module core_model (
    // Clock
    input wire aclk,
    // To the block
    output logic deep_sleep = 1'b0,
    output logic frame_valid = 1'b0,
    output logic [7:0] quality_metric = 8'h00,
    output logic [7:0] frame_dx = 8'h00,
    output logic [7:0] frame_dy = 8'h00
);
// Lines invert after a frame so stale data never passes as valid
task frame(input [7:0] q, input [7:0] x);
    begin
        @(posedge aclk);
        frame_valid <= 1'b1;
        {quality_metric, frame_dx, frame_dy} <= {q, x, ~x};
        @(posedge aclk);
        frame_valid <= 1'b0;
        {quality_metric, frame_dx, frame_dy} <= ~{q, x, ~x};
    end
endtask
endmodule

/* test/sleep2_iq_config_tb.sv */
// Self-checking bench: AXI4-Lite tasks, frames and poll timing.
// Assumes STEP_CYCLES of 4 so one poll step is four clocks.
`timescale 1ns/100ps
module sleep2_iq_config_tb;
logic aclk = 1'b0, aresetn = 1'b0;
logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
logic [3:0] s_axi_wstrb = 4'hf;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire deep_sleep, frame_valid, poll_pulse, motion_load_q;
wire [7:0] quality_metric, frame_dx, frame_dy, motion_x_q, motion_y_q;
wire [2:0] peak_weighting;
wire [3:0] quality_difference_level;
logic [15:0] em = 16'h0000;
int fails = 0, n_tests = 0, gap;
// Gate levels kept at or above the lowest working level; poll fields
logic [23:0] gate_v = 24'hfe_140a;
logic [11:0] poll_v = 12'hf90;
sleep2_iq_config #(.STEP_CYCLES(4)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .deep_sleep, .frame_valid, .quality_metric, .frame_dx, .frame_dy, .poll_pulse, .motion_x_q, .motion_y_q,
    .motion_load_q, .peak_weighting, .quality_difference_level);
core_model core_u (.aclk, .deep_sleep, .frame_valid, .quality_metric, .frame_dx, .frame_dy);
initial begin
    forever #5 aclk = ~aclk;
end
////////////////////////////////////////
task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    end
endtask
// Each channel drops valid at the edge that takes it; one idle edge follows
task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", r, s_axi_bresp);
        @(posedge aclk);
    end
endtask
task rd(input [7:0] a, input [31:0] d, input [1:0] r);
    begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rresp", r, s_axi_rresp);
        chk("rdata", d, s_axi_rdata);
        @(posedge aclk);
    end
endtask
// Frame, then the load pulse and held displacement one clock later
task fr(input [7:0] q, input [7:0] x, input logic e);
    begin
        core_u.frame(q, x);
        @(posedge aclk);
        chk("load", e, motion_load_q);
        if (e) em = {~x, x};
        chk("motion", em, {motion_y_q, motion_x_q});
    end
endtask
task summarize;
    begin
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    end
endtask
////////////////////////////////////////
initial begin
    #100000;
    fails++;
    summarize;
end
initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h30, 32'h0000_0092, 2'h0);
    rd(8'h34, 32'h0000_000a, 2'h0);
    rd(8'h38, 32'h0000_00e9, 2'h0);
    chk("peak", 32'h0000_0007, peak_weighting);
    chk("qdiff", 32'h0000_0009, quality_difference_level);
    fr(8'h0a, 8'h11, 1'b0);
    fr(8'h0b, 8'h22, 1'b1);
    wr(8'h38, 32'h0000_000f, 2'h0);
    rd(8'h38, 32'h0000_000f, 2'h0);
    chk("peak", 32'h0000_0000, peak_weighting);
    chk("qdiff", 32'h0000_000f, quality_difference_level);
    for (int i = 0; i < 3; i++) begin
        wr(8'h34, {24'h00_0000, gate_v[8*i +: 8]}, 2'h0);
        rd(8'h34, {24'h00_0000, gate_v[8*i +: 8]}, 2'h0);
        fr(gate_v[8*i +: 8], 8'h30 + i, 1'b0);
        fr(gate_v[8*i +: 8] + 8'h01, 8'h40 + i, 1'b1);
    end
    rd(8'h3c, 32'h0000_00ff, 2'h0);
    rd(8'h40, 32'h0000_bd42, 2'h0);
    // Byte lane 0 off: the gate must keep its value
    s_axi_wstrb <= 4'he;
    wr(8'h34, 32'h0000_0033, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(8'h34, 32'h0000_00fe, 2'h0);
    wr(8'h44, 32'h0000_0001, 2'h2);
    rd(8'h44, 32'h0000_0000, 2'h2);
    for (int i = 0; i < 3; i++) begin
        wr(8'h30, {24'h00_0000, poll_v[4*i +: 4], 4'h2}, 2'h0);
        rd(8'h30, {24'h00_0000, poll_v[4*i +: 4], 4'h2}, 2'h0);
        core_u.deep_sleep <= 1'b1;
        gap = 0;
        do begin
            @(posedge aclk);
            gap++;
        end while (poll_pulse !== 1'b1);
        chk("first", 4 * (poll_v[4*i +: 4] + 1) + 1, gap);
        gap = 0;
        do begin
            @(posedge aclk);
            gap++;
        end while (poll_pulse !== 1'b1);
        chk("period", 4 * (poll_v[4*i +: 4] + 1), gap);
        core_u.deep_sleep <= 1'b0;
        @(posedge aclk);
    end
    // Reset in mid-run must bring back the recognition, peak weighting and motion reset values
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h38, 32'h0000_00e9, 2'h0);
    rd(8'h40, 32'h0000_0000, 2'h0);
    chk("peak", 32'h0000_0007, peak_weighting);
    summarize;
end
endmodule
